// ==== common/adcs_pkg.sv ====
// Shared constants and types of the converter sequencer control block.
// Assumes a 32-bit AHB-Lite register bus and one 100 MHz system clock.
package adcs_pkg;

  // Bus and data widths
  localparam int ADCS_ADDR_W = 8;
  localparam int ADCS_BUS_W  = 32;
  localparam int ADCS_RES_W  = 12;
  localparam int ADCS_PINS   = 8;

  // Register byte offsets
  localparam logic [7:0] ADCS_OFS_RES_LOW  = 8'h00;
  localparam logic [7:0] ADCS_OFS_RES_HIGH = 8'h04;
  localparam logic [7:0] ADCS_OFS_CTRL     = 8'h08;
  localparam logic [7:0] ADCS_OFS_CLKSEL   = 8'h0C;

  // Field positions of converter_control, clock select and result low
  localparam int ADCS_CTRL_START_BIT = 7;
  localparam int ADCS_CTRL_PEND_BIT  = 6;
  localparam int ADCS_CTRL_PIN_LSB   = 3;
  localparam int ADCS_CTRL_CHAN_LSB  = 0;
  localparam int ADCS_CLKSEL_LSB     = 0;
  localparam int ADCS_RES_LOW_LSB    = 4;

  // Values after reset
  localparam logic [2:0] ADCS_PIN_RST    = 3'h0;
  localparam logic [2:0] ADCS_CHAN_RST   = 3'h0;
  localparam logic [1:0] ADCS_CLKSEL_RST = 2'h0;
  localparam logic       ADCS_PEND_RST   = 1'b1;

  // Conversion clock division ratios
  localparam logic [3:0] ADCS_DIV_00 = 4'h4;
  localparam logic [3:0] ADCS_DIV_01 = 4'h6;
  localparam logic [3:0] ADCS_DIV_10 = 4'h8;
  localparam logic [3:0] ADCS_DIV_11 = 4'hC;

  // Conversion length in conversion clock periods
  localparam int ADCS_CONV_TAD_DEF = 16;

  // Word transfer size
  localparam logic [2:0] ADCS_HSIZE_WORD = 3'h2;

  typedef enum logic [2:0] {
    ADCS_IDLE = 3'b001,
    ADCS_HOLD = 3'b010,
    ADCS_CONV = 3'b100
  } adcs_state_t;

  typedef struct packed {
    logic       start;
    logic [2:0] pin_analog_config;
    logic [2:0] channel_select;
  } adcs_ctrl_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } adcs_result_t;

endpackage

// ==== rtl/adcs_clkdiv.sv ====
// Conversion clock divider: one tick per conversion clock period.
// Assumes i_run is held high for the whole conversion.
`timescale 1ns/10ps
`default_nettype none
module adcs_clkdiv
  import adcs_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // Control
  input  wire logic       i_run,
  input  wire logic [1:0] i_div_sel,
  // Tick out
  output logic            o_tick
);

  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [3:0] ratio;

  always_comb begin
    case (i_div_sel)
      2'h0:    ratio = ADCS_DIV_00;
      2'h1:    ratio = ADCS_DIV_01;
      2'h2:    ratio = ADCS_DIV_10;
      default: ratio = ADCS_DIV_11;
    endcase
  end

  // Counter restarts whenever the converter is not running
  assign o_tick = i_run && (cnt == ratio - 4'h1);

  always_comb begin
    if (!i_run || o_tick) begin
      next_cnt = 4'h0;
    end else begin
      next_cnt = cnt + 4'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt <= 4'h0;
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/adcs_ctrl.sv ====
// Sequencer control for an eight-input 12-bit converter, AHB-Lite slave.
// Assumes the analog circuit presents a settled result on i_adc_data
// when the conversion count ends, and an outside interrupt controller.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Eight inputs, one converter, 12-bit result
// - Bits 11..4 high byte, 3..0 low nibble
// - Channel field routes input n
// - Config zero: all digital, converter off
// - Config code maps pins to analog
// - Full start pulse begins conversion
// - Start held high: reset, pending high
// - Pending cleared when conversion ends
// - Set request flag; interrupt only if enabled
// - Clock divided by 4, 6, 8, 12
// - Analog pins lose their pull-ups
// - Analog pins override port direction
// - Pin function changes by register writes
module adcs_ctrl
  import adcs_pkg::*;
#(
  parameter int CONV_TAD = ADCS_CONV_TAD_DEF
) (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_nrst,
  // AHB-Lite slave
  input  wire logic                   i_hsel,
  input  wire logic [ADCS_ADDR_W-1:0] i_haddr,
  input  wire logic [1:0]             i_htrans,
  input  wire logic                   i_hwrite,
  input  wire logic [2:0]             i_hsize,
  input  wire logic [ADCS_BUS_W-1:0]  i_hwdata,
  input  wire logic                   i_hready,
  output logic                        o_hreadyout,
  output logic                        o_hresp,
  output logic [ADCS_BUS_W-1:0]       o_hrdata,
  // Analog conversion circuit
  input  wire logic [ADCS_RES_W-1:0]  i_adc_data,
  output logic [2:0]                  o_chan_sel,
  output logic                        o_conv_reset,
  output logic                        o_conv_busy,
  output logic                        o_adc_power_down,
  // Shared port pins
  input  wire logic [ADCS_PINS-1:0]   i_pullup_cfg,
  input  wire logic [ADCS_PINS-1:0]   i_port_dir,
  output logic [ADCS_PINS-1:0]        o_analog_en,
  output logic [ADCS_PINS-1:0]        o_pullup_en,
  output logic [ADCS_PINS-1:0]        o_port_dir,
  // Interrupt controller
  input  wire logic                   i_irq_en,
  output logic                        o_irq_flag_set,
  output logic                        o_irq_req
);

  if (CONV_TAD < 1 || CONV_TAD > 255) begin : g_bad_tad
    $error("CONV_TAD must lie in 1..255");
  end

  localparam logic [7:0] TAD_LAST = 8'(CONV_TAD - 1);

  // Bus state
  logic                   rd_pend;
  logic                   wr_pend;
  logic [ADCS_ADDR_W-1:0] addr_q;
  logic [ADCS_BUS_W-1:0]  hrdata;
  logic                   next_rd_pend;
  logic                   next_wr_pend;
  logic [ADCS_ADDR_W-1:0] next_addr_q;
  logic [ADCS_BUS_W-1:0]  next_hrdata;
  logic                   accept;

  // Register state
  adcs_ctrl_t             ctrl;
  adcs_ctrl_t             next_ctrl;
  logic [1:0]             clksel;
  logic [1:0]             next_clksel;
  logic [ADCS_PINS-1:0]   analog;
  logic [ADCS_PINS-1:0]   next_analog;

  // Sequencer state
  adcs_state_t            state;
  adcs_state_t            next_state;
  logic                   pending;
  logic                   next_pending;
  logic [7:0]             tad_cnt;
  logic [7:0]             next_tad_cnt;
  adcs_result_t           result;
  adcs_result_t           next_result;
  logic                   irq_set;
  logic                   tick;
  logic                   done;

  // Bus handshake: writes take no wait, reads take one
  assign accept      = i_hsel && i_htrans[1] && i_hready;
  assign o_hreadyout = !rd_pend;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = hrdata;

  always_comb begin
    next_rd_pend = accept && !i_hwrite;
    next_wr_pend = accept && i_hwrite && (i_hsize == ADCS_HSIZE_WORD);
    next_addr_q  = accept ? i_haddr : addr_q;
    next_hrdata  = hrdata;
    if (rd_pend) begin
      next_hrdata = 32'h0000_0000;
      if (addr_q == ADCS_OFS_RES_LOW) begin
        next_hrdata[7:0] = result.low;
      end else if (addr_q == ADCS_OFS_RES_HIGH) begin
        next_hrdata[7:0] = result.high;
      end else if (addr_q == ADCS_OFS_CTRL) begin
        next_hrdata[ADCS_CTRL_START_BIT] = ctrl.start;
        next_hrdata[ADCS_CTRL_PEND_BIT]  = pending;
        next_hrdata[ADCS_CTRL_PIN_LSB +: 3] = ctrl.pin_analog_config;
        next_hrdata[ADCS_CTRL_CHAN_LSB +: 3] = ctrl.channel_select;
      end else if (addr_q == ADCS_OFS_CLKSEL) begin
        next_hrdata[ADCS_CLKSEL_LSB +: 2] = clksel;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_pend <= 1'b0;
      wr_pend <= 1'b0;
      addr_q  <= '0;
      hrdata  <= 32'h0000_0000;
    end else begin
      rd_pend <= next_rd_pend;
      wr_pend <= next_wr_pend;
      addr_q  <= next_addr_q;
      hrdata  <= next_hrdata;
    end
  end

  // Register writes; result registers accept none
  always_comb begin
    next_ctrl   = ctrl;
    next_clksel = clksel;
    if (wr_pend) begin
      if (addr_q == ADCS_OFS_CTRL) begin
        next_ctrl.start = i_hwdata[ADCS_CTRL_START_BIT];
        next_ctrl.pin_analog_config = i_hwdata[ADCS_CTRL_PIN_LSB +: 3];
        next_ctrl.channel_select = i_hwdata[ADCS_CTRL_CHAN_LSB +: 3];
      end else if (addr_q == ADCS_OFS_CLKSEL) begin
        next_clksel = i_hwdata[ADCS_CLKSEL_LSB +: 2];
      end
    end
    // Pin map by configuration code
    case (next_ctrl.pin_analog_config)
      3'h0:    next_analog = 8'h00;
      3'h1:    next_analog = 8'h01;
      3'h2:    next_analog = 8'h03;
      3'h3:    next_analog = 8'h07;
      3'h4:    next_analog = 8'h0E;
      3'h5:    next_analog = 8'h3F;
      3'h6:    next_analog = 8'h3F;
      default: next_analog = 8'hFF;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl   <= '{1'b0, ADCS_PIN_RST, ADCS_CHAN_RST};
      clksel <= ADCS_CLKSEL_RST;
      analog <= 8'h00;
    end else begin
      ctrl   <= next_ctrl;
      clksel <= next_clksel;
      analog <= next_analog;
    end
  end

  // Pin and converter outputs
  assign o_chan_sel       = ctrl.channel_select;
  assign o_analog_en      = analog;
  assign o_adc_power_down = (analog == 8'h00);
  assign o_pullup_en      = i_pullup_cfg & ~analog;
  assign o_port_dir       = i_port_dir | analog;
  assign o_conv_reset     = (state == ADCS_HOLD);
  assign o_conv_busy      = (state == ADCS_CONV);
  assign o_irq_flag_set   = irq_set;
  assign o_irq_req        = irq_set && i_irq_en;

  adcs_clkdiv u_div (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .i_run     (state == ADCS_CONV),
    .i_div_sel (clksel),
    .o_tick    (tick)
  );

  // Conversion ends after CONV_TAD periods; a new start cancels it
  assign done = (state == ADCS_CONV) && tick && !ctrl.start
                && (tad_cnt == TAD_LAST);

  always_comb begin
    next_state   = state;
    next_pending = pending;
    next_result  = result;
    next_tad_cnt = 8'h00;
    case (state)
      ADCS_IDLE: begin
        if (ctrl.start) begin
          next_state = ADCS_HOLD;
        end
      end
      ADCS_HOLD: begin
        if (!ctrl.start) begin
          next_state = ADCS_CONV;
        end
      end
      ADCS_CONV: begin
        if (ctrl.start) begin
          next_state = ADCS_HOLD;
        end else if (done) begin
          next_state = ADCS_IDLE;
        end else begin
          next_tad_cnt = tick ? tad_cnt + 8'h01 : tad_cnt;
        end
      end
      default: next_state = ADCS_IDLE;
    endcase
    if (next_state == ADCS_HOLD) begin
      next_pending = 1'b1;
    end else if (done) begin
      next_pending = 1'b0;
    end
    if (done) begin
      next_result.high = i_adc_data[11:4];
      next_result.low  = {i_adc_data[3:0], 4'h0};
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state   <= ADCS_IDLE;
      pending <= ADCS_PEND_RST;
      tad_cnt <= 8'h00;
      result  <= '{8'h00, 8'h00};
      irq_set <= 1'b0;
    end else begin
      state   <= next_state;
      pending <= next_pending;
      tad_cnt <= next_tad_cnt;
      result  <= next_result;
      irq_set <= done;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_release;
    (state == ADCS_HOLD) && !ctrl.start;
  endsequence

  sequence s_finish;
    done;
  endsequence

  property p_power_down;
    (ctrl.pin_analog_config == 3'h0) |-> o_adc_power_down && !(|o_analog_en);
  endproperty
  a_power_down: assert property (p_power_down)
    else $error("converter not powered down with all pins digital");

  property p_pin_map;
    (ctrl.pin_analog_config == 3'h4) |-> (o_analog_en == 8'h0E);
  endproperty
  a_pin_map: assert property (p_pin_map)
    else $error("code 4 does not map pins 3..1");

  property p_pullup;
    !(|(o_pullup_en & o_analog_en)) && &(o_port_dir | ~o_analog_en);
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("analog pin keeps pull-up or output direction");

  property p_hold;
    (state == ADCS_HOLD) |-> o_conv_reset && pending && !o_conv_busy;
  endproperty
  a_hold: assert property (p_hold)
    else $error("held start does not reset converter");

  property p_start;
    s_release |=> o_conv_busy ##1 (o_conv_busy || state == ADCS_HOLD);
  endproperty
  a_start: assert property (p_start)
    else $error("start pulse did not begin a conversion");

  property p_finish;
    s_finish |=> !pending && o_irq_flag_set
      && result.high == $past(i_adc_data[11:4])
      && result.low == {$past(i_adc_data[3:0]), 4'h0};
  endproperty
  a_finish: assert property (p_finish)
    else $error("end of conversion not reported with result");

  property p_irq;
    o_irq_req |-> o_irq_flag_set && i_irq_en && $past(done);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt raised without enabled end of conversion");

  property p_result_hold;
    !done |=> $stable(result);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result changed without a finished conversion");

  property p_length;
    (s_release ##1 !ctrl.start [*2]) |-> ##[1:200] (done || ctrl.start);
  endproperty
  a_length: assert property (p_length)
    else $error("conversion did not end in time");

endmodule
`default_nettype wire

// ==== verif/adcs_analog_model.sv ====
// Behavioural analog circuit and port pin side of the sequencer.
// Assumes the sequencer drives channel, reset and power-down levels.
`timescale 1ns/10ps
`default_nettype none
module adcs_analog_model
  import adcs_pkg::*;
(
  // From the sequencer
  input  wire logic                  i_clk,
  input  wire logic [2:0]            i_chan_sel,
  input  wire logic                  i_conv_reset,
  input  wire logic                  i_power_down,
  // To the sequencer
  output logic [ADCS_RES_W-1:0]      o_adc_data,
  output logic [ADCS_PINS-1:0]       o_pullup_cfg,
  output logic [ADCS_PINS-1:0]       o_port_dir
);
  logic [ADCS_RES_W-1:0] junk = 12'h0A5;
  // Garbage that changes every cycle while off or in reset
  always_ff @(posedge i_clk) begin
    junk <= ~junk;
  end
  // Settled sample of the selected input
  assign o_adc_data   = (i_power_down | i_conv_reset) ? junk :
                        {i_chan_sel, 9'h0C5};
  assign o_pullup_cfg = 8'hA5;
  assign o_port_dir   = 8'h3C;
endmodule
`default_nettype wire

// ==== verif/adcs_ctrl_bench.sv ====
// Self-checking bench of the sequencer over AHB-Lite register tasks.
// Assumes a short conversion length and the analog model beside it.
`timescale 1ns/10ps
`default_nettype none
module adcs_ctrl_bench;
  import adcs_pkg::*;
  localparam int CONVERSION_CLOCK_PERIOD = 2;
  logic        clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        irq_en = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = ADCS_HSIZE_WORD;
  logic [31:0] hwdata = 32'h0000_0000, hrdata;
  logic        hready, hresp, conv_reset, busy, pdn, flag, irq;
  logic [11:0] adc_data;
  logic [2:0]  chan;
  logic [7:0]  pu_cfg, pdir, an_en, pu_en, pdir_o;
  logic [7:0]  amap [8] = '{8'h00, 8'h01, 8'h03, 8'h07,
                            8'h0E, 8'h3F, 8'h3F, 8'hFF};
  int          ratio [4] = '{4, 6, 8, 12};
  int          errors = 0, samples_checked = 0, n, nb;

  adcs_ctrl #(.CONV_TAD(CONVERSION_CLOCK_PERIOD)) uut (
    .i_clk(clk), .i_nrst(nrst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
    .o_hresp(hresp), .o_hrdata(hrdata), .i_adc_data(adc_data),
    .o_chan_sel(chan), .o_conv_reset(conv_reset), .o_conv_busy(busy),
    .o_adc_power_down(pdn), .i_pullup_cfg(pu_cfg), .i_port_dir(pdir),
    .o_analog_en(an_en), .o_pullup_en(pu_en), .o_port_dir(pdir_o),
    .i_irq_en(irq_en), .o_irq_flag_set(flag), .o_irq_req(irq));

  adcs_analog_model model (
    .i_clk(clk), .i_chan_sel(chan), .i_conv_reset(conv_reset),
    .i_power_down(pdn), .o_adc_data(adc_data),
    .o_pullup_cfg(pu_cfg), .o_port_dir(pdir));

  always #5 clk = ~clk;

  task automatic chk(input logic [31:0] got, exp, input string w);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask

  task automatic results();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic hang(input string w);
    errors++;
    $display("ERROR %0t timeout %s", $time, w);
    results();
  endtask

  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      k++;
      if (k > 50) hang("bus");
      @(posedge clk);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rv);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rv = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input string w);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    chk(x, e, w);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk(32'(pdn), 32'h0000_0001, "pdn rst");
    rd_chk(ADCS_OFS_CTRL, 32'h0000_0040, "ctrl rst");
    rd_chk(ADCS_OFS_CLKSEL, 32'h0000_0000, "clksel rst");
    rd_chk(8'h10, 32'h0000_0000, "unmapped");
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      wr(ADCS_OFS_CTRL, 32'(c << 3));
      @(posedge clk);
      chk(32'(an_en), 32'(amap[c]), "analog");
      chk(32'(pu_en), 32'(pu_cfg & ~amap[c]), "pullup");
      chk(32'(pdir_o), 32'(pdir | amap[c]), "dir");
      chk(32'(pdn), 32'(c == 0), "pdn");
    end
    $display("test pins done");
    for (int ch = 0; ch < 8; ch++) begin
      irq_en <= ch[0];
      wr(ADCS_OFS_CLKSEL, 32'(ch % 4));
      wr(ADCS_OFS_CTRL, 32'h0000_00F8 | 32'(ch));
      repeat (2) @(posedge clk);
      chk(32'(conv_reset), 32'h0000_0001, "hold");
      chk(32'(chan), 32'(ch), "chan");
      rd_chk(ADCS_OFS_CTRL, 32'h0000_00F8 | 32'(ch), "pend hi");
      repeat (20) begin
        @(posedge clk);
        chk(32'(busy | flag), 32'h0000_0000, "held");
      end
      wr(ADCS_OFS_CTRL, 32'h0000_0038 | 32'(ch));
      n = 0;
      nb = 0;
      while (flag !== 1'b1) begin
        n++;
        if (n > 500) hang("conversion");
        @(posedge clk);
        if (busy === 1'b1) nb++;
      end
      chk(32'(nb), 32'(CONVERSION_CLOCK_PERIOD * ratio[ch % 4]), "length");
      chk(32'(irq), 32'(ch % 2), "irq");
      rd_chk(ADCS_OFS_RES_HIGH, 32'((ch << 5) | 12), "high");
      rd_chk(ADCS_OFS_RES_LOW, 32'h0000_0050, "low");
      rd_chk(ADCS_OFS_CTRL, 32'h0000_0038 | 32'(ch), "pend lo");
    end
    $display("test conversions done");
    wr(ADCS_OFS_RES_HIGH, 32'h0000_00FF);
    wr(ADCS_OFS_RES_LOW, 32'h0000_00FF);
    wr(ADCS_OFS_CTRL, 32'h0000_0039);
    hsize <= 3'h0;
    wr(ADCS_OFS_CLKSEL, 32'h0000_0001);
    hsize <= ADCS_HSIZE_WORD;
    rd_chk(ADCS_OFS_CLKSEL, 32'h0000_0003, "narrow");
    rd_chk(ADCS_OFS_RES_HIGH, 32'h0000_00EC, "ro high");
    rd_chk(ADCS_OFS_RES_LOW, 32'h0000_0050, "ro low");
    $display("test hold done");
    wr(ADCS_OFS_CTRL, 32'h0000_00B9);
    wr(ADCS_OFS_CTRL, 32'h0000_0039);
    repeat (3) @(posedge clk);
    chk(32'(busy), 32'h0000_0001, "running");
    wr(ADCS_OFS_CTRL, 32'h0000_00B9);
    repeat (2) @(posedge clk);
    rd_chk(ADCS_OFS_CTRL, 32'h0000_00F9, "abort pend");
    repeat (30) begin
      @(posedge clk);
      chk(32'(busy | flag), 32'h0000_0000, "aborted");
    end
    rd_chk(ADCS_OFS_RES_HIGH, 32'h0000_00EC, "abort high");
    $display("test abort done");
    results();
  end
endmodule
`default_nettype wire
